//--- sbl_host_model.sv
// host-side byte model driving the loader's uart link
module sbl_host_model
  import sbl_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // byte link toward the loader
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // random stalls on the return path, the loader must hold its byte
  always @(negedge sys_clk) begin
    tx_ready <= ($urandom_range(2) != 0);
  end

  //////////////////////////////////////////////////////////////////////////
  // one byte per pulse; data flips when idle so a stale byte never repeats
  task automatic send_byte(input logic [7:0] b);
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_data  = b;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_data  = ~b;
  endtask

  // length, payload sum, then command and its parameters
  task automatic send_pkt(input logic [7:0] p[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (p[i]) s += p[i];
    send_byte(8'(p.size() + 2));
    send_byte(s);
    foreach (p[i]) send_byte(p[i]);
  endtask

  // zero padding ahead of the reply, as the sync serial port needs
  task automatic reply(input logic [7:0] b);
    send_byte(ZERO_BYTE);
    send_byte(b);
  endtask

  task automatic sync_pair();
    send_byte(SYNC_BYTE);
    send_byte(SYNC_BYTE);
  endtask
endmodule

//--- sbl_loader.sv
// packet interpreter of the serial boot loader
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - first packet byte is total length, counting length and sum bytes
// R2 - second byte is the sum of payload bytes only
// R3 - payload holds length minus two bytes
// R4 - reply 0xcc on good reception, 0x33 on bad reception
// R5 - acknowledge reflects reception only, never command validity
// R6 - host reads until first non-zero byte, taken as reply
// R7 - outgoing packet may be preceded by zeros; then length, sum, payload
// R8 - after first non-zero byte, rest of packet goes without gaps
// R9 - host answers every device packet; resends command after a NAK
// R10 - device skips leading zeros, first non-zero byte is host reply
// R11 - first payload byte is command code, then its parameters
// R12 - three-byte ping sets last status to success only
// R13 - status query: acknowledge, then one-byte packet with last status
// R14 - download setup: 11 bytes, address then count, msb first, stored
// R15 - download setup erases region before acknowledging
// R16 - data command programs at current address, address auto-advances
// R17 - host sends data only after setup or data, max 8 bytes
// R18 - programming ends when the setup byte count is reached
// R19 - a NAK leaves the program address unchanged
// R20 - host queries status after setup and each data command
// R21 - run: 7 bytes, address msb first, acknowledge before jump
// R22 - reset: 3 bytes, acknowledge first, then full system reset; the code does not check the length
// R23 - first port used locks out the other until reset
// R24 - two 0x55 bytes on uart before packets, answered with 0xcc
// R25 - bad sum or length below three gets a NAK
// R26 - unknown command or data without download records failure
module sbl_loader
  import sbl_pkg::*;
(
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // uart byte side
  input  wire logic        uart_rx_valid,
  input  wire logic [7:0]  uart_rx_data,
  output logic             uart_tx_valid,
  input  wire logic        uart_tx_ready,
  // sync serial port byte side
  input  wire logic        sync_serial_port_rx_valid,
  input  wire logic [7:0]  sync_serial_port_rx_data,
  output logic             sync_serial_port_tx_valid,
  input  wire logic        sync_serial_port_tx_ready,
  // shared transmit byte
  output logic      [7:0]  tx_data,
  // flash erase
  output logic             erase_req,
  output logic      [31:0] erase_addr,
  output logic      [31:0] erase_size,
  input  wire logic        erase_done,
  input  wire logic        erase_ok,
  // flash program
  output logic             prog_req,
  output logic      [31:0] prog_addr,
  output logic      [7:0]  prog_data,
  input  wire logic        prog_done,
  input  wire logic        prog_ok,
  // execution control
  output logic             run_req,
  output logic      [31:0] run_addr,
  output logic             sys_reset_req,
  output logic      [7:0]  last_status
);

  //////////////////////////////////////////////////////////////////////////
  // state

  sbl_state_e  state_r,   state_nxt;
  sbl_port_e   lock_r,    lock_nxt;
  sbl_post_e   post_r,    post_nxt;
  logic [7:0]  len_r,     len_nxt;
  logic [7:0]  chk_r,     chk_nxt;
  logic [7:0]  cnt_r,     cnt_nxt;
  logic [7:0]  pi_r,      pi_nxt;
  logic [7:0]  status_r,  status_nxt;
  logic [7:0]  txd_r,     txd_nxt;
  logic [7:0]  pdata_r,   pdata_nxt;
  logic [1:0]  txi_r,     txi_nxt;
  logic [1:0]  sync_r,    sync_nxt;
  logic [31:0] addr_r,    addr_nxt;
  logic [31:0] remain_r,  remain_nxt;
  logic [31:0] runa_r,    runa_nxt;
  logic        active_r,  active_nxt;
  logic [7:0]  buf_r      [PAY_MAX];
  logic [7:0]  buf_nxt    [PAY_MAX];

  logic        rx_v;
  logic [7:0]  rx_d;
  sbl_port_e   rx_port;
  logic        tx_v;
  logic        tx_rdy;
  logic        tx_fire;
  logic        sum_clr;
  logic        sum_add;
  logic [7:0]  sum;
  logic        prog_end;
  logic [7:0]  last_idx;

  //////////////////////////////////////////////////////////////////////////
  // port selection; the phy keeps bytes on our clock, so no synchroniser

  always_comb begin
    rx_v    = 1'b0;
    rx_d    = ZERO_BYTE;
    rx_port = PORT_NONE;
    if (lock_r != PORT_SYNC && uart_rx_valid) begin // see R23
      rx_v    = 1'b1;
      rx_d    = uart_rx_data;
      rx_port = PORT_UART;
    end else if (lock_r != PORT_UART && sync_serial_port_rx_valid) begin
      rx_v    = 1'b1;
      rx_d    = sync_serial_port_rx_data;
      rx_port = PORT_SYNC;
    end
  end

  assign tx_v    = (state_r == S_ACK) || (state_r == S_TXPKT);
  assign tx_rdy  = (lock_r == PORT_SYNC) ? sync_serial_port_tx_ready
                                         : uart_tx_ready;
  assign tx_fire = tx_v && tx_rdy && ce;
  assign uart_tx_valid             = tx_v && (lock_r == PORT_UART);
  assign sync_serial_port_tx_valid = tx_v && (lock_r == PORT_SYNC);

  // last payload index is length minus three
  assign last_idx = 8'(len_r - LEN_MIN); // see R3
  assign prog_end = (pi_r > last_idx) || (remain_r == 32'h0);

  sbl_sum8 u_sum (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (sum_clr),
    .add     (sum_add),
    .din     (rx_d),
    .sum     (sum)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt  = state_r;
    lock_nxt   = lock_r;
    post_nxt   = post_r;
    len_nxt    = len_r;
    chk_nxt    = chk_r;
    cnt_nxt    = cnt_r;
    pi_nxt     = pi_r;
    status_nxt = status_r;
    txd_nxt    = txd_r;
    pdata_nxt  = pdata_r;
    txi_nxt    = txi_r;
    sync_nxt   = sync_r;
    addr_nxt   = addr_r;
    remain_nxt = remain_r;
    runa_nxt   = runa_r;
    active_nxt = active_r;
    buf_nxt    = buf_r;
    sum_clr    = 1'b0;
    sum_add    = 1'b0;
    case (state_r)
      S_IDLE: begin
        // zero padding between packets is skipped
        if (rx_v && rx_d != ZERO_BYTE) begin // see R10
          if (lock_r == PORT_NONE && rx_port == PORT_UART &&
              rx_d == SYNC_BYTE) begin // see R24
            sync_nxt = 2'(sync_r + 2'h1);
            if (sync_r == SYNC_ONE) begin
              lock_nxt  = PORT_UART;
              sync_nxt  = 2'h0;
              txd_nxt   = ACK_BYTE;
              post_nxt  = P_NONE;
              state_nxt = S_ACK;
            end
          end else begin
            lock_nxt = rx_port; // see R23
            len_nxt  = rx_d; // see R1
            sum_clr  = 1'b1;
            if (rx_d < LEN_MIN) begin // see R25
              txd_nxt   = NAK_BYTE;
              post_nxt  = P_NONE;
              state_nxt = S_ACK;
            end else begin
              state_nxt = S_SUM;
            end
          end
        end
      end
      S_SUM: begin
        if (rx_v) begin
          chk_nxt   = rx_d; // see R2
          cnt_nxt   = ZERO_BYTE;
          state_nxt = S_DATA;
        end
      end
      S_DATA: begin
        if (rx_v) begin
          sum_add = 1'b1; // see R2
          // overlong payload is summed but not stored
          if (cnt_r < PAY_MAX_B) begin
            buf_nxt[4'(cnt_r)] = rx_d;
          end
          cnt_nxt = 8'(cnt_r + 8'h01);
          if (cnt_r == last_idx) begin // see R3
            state_nxt = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        post_nxt  = P_NONE;
        state_nxt = S_ACK;
        if (sum != chk_r) begin // see R25
          txd_nxt = NAK_BYTE; // see R4 R19
        end else begin
          txd_nxt = ACK_BYTE; // see R4 R5
          case (buf_r[0]) // see R11
            CMD_PING: begin
              status_nxt = (len_r == LEN_SHORT) ? ST_SUCCESS
                                                : ST_INVALID; // see R12
            end
            CMD_QUERY: begin
              post_nxt = P_STATUS; // see R13
            end
            CMD_DOWNLOAD: begin
              if (len_r == LEN_DOWNLOAD) begin // see R14
                addr_nxt   = {buf_r[1], buf_r[2], buf_r[3], buf_r[4]};
                remain_nxt = {buf_r[5], buf_r[6], buf_r[7], buf_r[8]};
                active_nxt = 1'b0;
                state_nxt  = S_ERASE; // see R15
              end else begin
                status_nxt = ST_INVALID;
              end
            end
            CMD_DATA: begin
              if (!active_r || len_r > LEN_DOWNLOAD) begin
                status_nxt = ST_FAIL; // see R26
              end else begin
                status_nxt = ST_SUCCESS;
                pi_nxt     = 8'h01;
                pdata_nxt  = buf_r[1];
                state_nxt  = S_PROG; // see R16
              end
            end
            CMD_RUN: begin
              if (len_r == LEN_RUN) begin // see R21
                runa_nxt   = {buf_r[1], buf_r[2], buf_r[3], buf_r[4]};
                status_nxt = ST_SUCCESS;
                post_nxt   = P_RUN;
              end else begin
                status_nxt = ST_INVALID;
              end
            end
            CMD_RESET: begin
              post_nxt = P_RST; // see R22
            end
            default: begin
              status_nxt = ST_UNKNOWN; // see R26
            end
          endcase
        end
      end
      S_ERASE: begin
        // reply held back until the whole region is erased
        if (erase_done) begin // see R15
          status_nxt = erase_ok ? ST_SUCCESS : ST_FAIL;
          active_nxt = erase_ok && (remain_r != 32'h0);
          state_nxt  = S_ACK;
        end
      end
      S_PROG: begin
        if (prog_end) begin
          state_nxt = S_ACK;
        end else if (prog_done) begin
          if (prog_ok) begin
            addr_nxt   = 32'(addr_r + 32'h1); // see R16
            remain_nxt = 32'(remain_r - 32'h1);
            pi_nxt     = 8'(pi_r + 8'h01);
            if (pi_r < 8'h08) begin
              pdata_nxt = buf_r[4'(pi_r + 8'h01)];
            end
            if (remain_r == 32'h1) begin
              active_nxt = 1'b0; // see R18
            end
          end else begin
            status_nxt = ST_FAIL;
            state_nxt  = S_ACK;
          end
        end
      end
      S_ACK: begin
        if (tx_fire) begin
          case (post_r)
            P_STATUS: begin
              txi_nxt   = 2'h0;
              txd_nxt   = LEN_REPLY; // see R7
              state_nxt = S_TXPKT;
            end
            P_RUN:   state_nxt = S_RUN; // see R21
            P_RST:   state_nxt = S_RST; // see R22
            default: state_nxt = S_IDLE;
          endcase
        end
      end
      S_TXPKT: begin
        // one byte payload, so sum equals the status byte
        if (tx_fire) begin // see R8
          txd_nxt = status_r;
          txi_nxt = 2'(txi_r + 2'h1);
          if (txi_r == TX_LAST) begin
            state_nxt = S_WREPLY;
          end
        end
      end
      S_WREPLY: begin
        // either reply ends it; after a nak the host asks again
        if (rx_v && rx_d != ZERO_BYTE) begin // see R10 R9
          state_nxt = S_IDLE;
        end
      end
      S_RUN:   state_nxt = S_IDLE;
      S_RST:   state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r  <= S_IDLE;
      lock_r   <= PORT_NONE;
      post_r   <= P_NONE;
      len_r    <= ZERO_BYTE;
      chk_r    <= ZERO_BYTE;
      cnt_r    <= ZERO_BYTE;
      pi_r     <= ZERO_BYTE;
      status_r <= ST_RESET;
      txd_r    <= ZERO_BYTE;
      pdata_r  <= ZERO_BYTE;
      txi_r    <= 2'h0;
      sync_r   <= 2'h0;
      addr_r   <= 32'h0;
      remain_r <= 32'h0;
      runa_r   <= 32'h0;
      active_r <= 1'b0;
      for (int i = 0; i < PAY_MAX; i++) begin
        buf_r[i] <= ZERO_BYTE;
      end
    end else if (ce) begin
      state_r  <= state_nxt;
      lock_r   <= lock_nxt;
      post_r   <= post_nxt;
      len_r    <= len_nxt;
      chk_r    <= chk_nxt;
      cnt_r    <= cnt_nxt;
      pi_r     <= pi_nxt;
      status_r <= status_nxt;
      txd_r    <= txd_nxt;
      pdata_r  <= pdata_nxt;
      txi_r    <= txi_nxt;
      sync_r   <= sync_nxt;
      addr_r   <= addr_nxt;
      remain_r <= remain_nxt;
      runa_r   <= runa_nxt;
      active_r <= active_nxt;
      buf_r    <= buf_nxt;
    end
  end

  assign tx_data       = txd_r;
  assign erase_req     = (state_r == S_ERASE);
  assign erase_addr    = addr_r;
  assign erase_size    = remain_r;
  assign prog_req      = (state_r == S_PROG) && !prog_end;
  assign prog_addr     = addr_r;
  assign prog_data     = pdata_r;
  assign run_req       = (state_r == S_RUN);
  assign run_addr      = runa_r;
  assign sys_reset_req = (state_r == S_RST);
  assign last_status   = status_r;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence good_pkt_s;
    ce && state_r == S_EXEC && sum == chk_r;
  endsequence

  sequence ack_out_s(sbl_post_e p);
    tx_fire && state_r == S_ACK && post_r == p;
  endsequence

  bad_sum_nak_a: assert property ( // see R25
    ce && state_r == S_EXEC && sum != chk_r
    |=> state_r == S_ACK && tx_data == NAK_BYTE
  ) else $error("bad sum not answered with nak");

  good_ack_a: assert property ( // see R4
    good_pkt_s |=> tx_data == ACK_BYTE
  ) else $error("good packet not acknowledged");

  nak_keeps_addr_a: assert property ( // see R19
    ce && state_r == S_EXEC && sum != chk_r |=> $stable(addr_r) [*3]
  ) else $error("address moved after nak");

  ping_status_a: assert property ( // see R12
    good_pkt_s ##0 (buf_r[0] == CMD_PING && len_r == LEN_SHORT)
    |=> status_r == ST_SUCCESS && state_r == S_ACK
  ) else $error("ping did not set success");

  lock_hold_a: assert property ( // see R23
    lock_r != PORT_NONE |=> lock_r == $past(lock_r)
  ) else $error("port lock changed");

  one_port_tx_a: assert property ( // see R23
    !(uart_tx_valid && sync_serial_port_tx_valid)
  ) else $error("both ports transmitting");

  run_after_ack_a: assert property ( // see R21
    ack_out_s(P_RUN) |=> run_req ##1 !run_req
  ) else $error("run not issued right after ack");

  reset_after_ack_a: assert property ( // see R22
    ack_out_s(P_RST) |=> sys_reset_req
  ) else $error("reset not issued right after ack");

  reply_no_gap_a: assert property ( // see R8
    tx_fire && state_r == S_TXPKT && txi_r != TX_LAST |=> uart_tx_valid ||
    sync_serial_port_tx_valid
  ) else $error("gap inside outgoing packet");

  count_end_a: assert property ( // see R18
    ce && state_r == S_PROG && prog_done && prog_ok && !prog_end &&
    remain_r == 32'h1 |=> !active_r && remain_r == 32'h0
  ) else $error("programming did not end at count");

  download_store_a: assert property ( // see R14
    good_pkt_s ##0 (buf_r[0] == CMD_DOWNLOAD && len_r == LEN_DOWNLOAD)
    |=> addr_r == $past({buf_r[1], buf_r[2], buf_r[3], buf_r[4]})
        && erase_req
  ) else $error("download setup not stored");

endmodule

//--- sbl_pkg.sv
// constants, codes and types for the serial boot packet loader
package sbl_pkg;

  // reply and framing bytes
  localparam logic [7:0] ACK_BYTE  = 8'hcc;
  localparam logic [7:0] NAK_BYTE  = 8'h33;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // command codes, first payload byte
  localparam logic [7:0] CMD_PING     = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN      = 8'h22;
  localparam logic [7:0] CMD_QUERY    = 8'h23;
  localparam logic [7:0] CMD_DATA     = 8'h24;
  localparam logic [7:0] CMD_RESET    = 8'h25;

  // packet lengths, length and sum bytes included
  localparam logic [7:0] LEN_MIN      = 8'h03;
  localparam logic [7:0] LEN_SHORT    = 8'h03;
  localparam logic [7:0] LEN_RUN      = 8'h07;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0b;
  localparam logic [7:0] LEN_REPLY    = 8'h03;

  // payload store: command byte plus eight data bytes
  localparam int         PAY_MAX      = 9;
  localparam logic [7:0] PAY_MAX_B    = 8'h09;

  // status codes; values are arbitrary
  localparam logic [7:0] ST_SUCCESS = 8'h01;
  localparam logic [7:0] ST_UNKNOWN = 8'h02;
  localparam logic [7:0] ST_INVALID = 8'h03;
  localparam logic [7:0] ST_FAIL    = 8'h04;
  localparam logic [7:0] ST_RESET   = 8'h00;

  // reply packet byte index and sync count
  localparam logic [1:0] TX_LAST  = 2'h2;
  localparam logic [1:0] SYNC_ONE = 2'h1;

  typedef enum logic [3:0] {
    S_IDLE, S_SUM, S_DATA, S_EXEC, S_ERASE, S_PROG,
    S_ACK, S_TXPKT, S_WREPLY, S_RUN, S_RST
  } sbl_state_e;

  typedef enum logic [1:0] {PORT_NONE, PORT_UART, PORT_SYNC} sbl_port_e;

  typedef enum logic [1:0] {P_NONE, P_STATUS, P_RUN, P_RST} sbl_post_e;

endpackage

//--- sbl_sum8.sv
// modulo-256 running sum of payload bytes
module sbl_sum8
  import sbl_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // control and data
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] din,
  output logic      [7:0] sum
);

  logic [7:0] sum_r;
  logic [7:0] sum_nxt;

  always_comb begin
    sum_nxt = sum_r;
    if (clr) begin
      sum_nxt = ZERO_BYTE;
    end else if (add) begin
      sum_nxt = 8'(sum_r + din);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sum_r <= ZERO_BYTE;
    end else if (ce) begin
      sum_r <= sum_nxt;
    end
  end

  assign sum = sum_r;

endmodule

//--- serial_boot_packet_loader_tb_top.sv
// self-checking bench for the serial boot packet loader
module serial_boot_packet_loader_tb_top
  import sbl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        uart_rx_valid, uart_tx_valid, uart_tx_ready;
  logic [7:0]  uart_rx_data, tx_data, prog_data, last_status;
  logic        sp_rx_valid = 1'b0;
  logic [7:0]  sp_rx_data = 8'h00;
  logic        sp_tx_valid, erase_req, prog_req, run_req, sys_reset_req;
  logic        erase_done = 1'b0;
  logic        prog_done  = 1'b0;
  logic [31:0] erase_addr, erase_size, prog_addr, run_addr;
  logic [31:0] exp_addr, exp_size;
  logic [7:0]  exp_q[$];
  logic [39:0] prog_q[$];
  logic        in_pkt = 1'b0;
  int          n_mismatch, comparisons, cycles;

  sbl_loader i_sbl_loader (
    .sys_clk                   (sys_clk),
    .sys_rst                   (sys_rst),
    .ce                        (1'b1),
    .uart_rx_valid             (uart_rx_valid),
    .uart_rx_data              (uart_rx_data),
    .uart_tx_valid             (uart_tx_valid),
    .uart_tx_ready             (uart_tx_ready),
    .sync_serial_port_rx_valid (sp_rx_valid),
    .sync_serial_port_rx_data  (sp_rx_data),
    .sync_serial_port_tx_valid (sp_tx_valid),
    .sync_serial_port_tx_ready (1'b1),
    .tx_data                   (tx_data),
    .erase_req                 (erase_req),
    .erase_addr                (erase_addr),
    .erase_size                (erase_size),
    .erase_done                (erase_done),
    .erase_ok                  (1'b1),
    .prog_req                  (prog_req),
    .prog_addr                 (prog_addr),
    .prog_data                 (prog_data),
    .prog_done                 (prog_done),
    .prog_ok                   (1'b1),
    .run_req                   (run_req),
    .run_addr                  (run_addr),
    .sys_reset_req             (sys_reset_req),
    .last_status               (last_status)
  );

  sbl_host_model i_sbl_host_model (
    .sys_clk  (sys_clk),
    .rx_valid (uart_rx_valid),
    .rx_data  (uart_rx_data),
    .tx_ready (uart_tx_ready)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // every byte the loader hands over on uart is matched to the oldest note
  always @(posedge sys_clk) begin
    if (in_pkt) check(uart_tx_valid, 1'b1);
    in_pkt = 1'b0;
    if (!sys_rst && uart_tx_valid && uart_tx_ready) begin
      check(tx_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
      in_pkt = (exp_q.size() != 0);
    end
    if (sp_tx_valid) check(1'b1, 1'b0);
  end

  // flash stand-in with random latency; checks every write in order
  always @(negedge sys_clk) begin
    erase_done <= erase_req && !erase_done && ($urandom_range(3) == 0);
    prog_done  <= prog_req && !prog_done && ($urandom_range(2) == 0);
  end

  always @(posedge sys_clk) begin
    logic [39:0] e;
    if (prog_req && prog_done) begin
      e = prog_q.size() != 0 ? prog_q.pop_front() : 'x;
      check(prog_addr, e[39:8]);
      check(prog_data, e[7:0]);
    end
    if (erase_req && erase_done) begin
      check(erase_addr, exp_addr);
      check(erase_size, exp_size);
    end
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bounded wait for all noted bytes, then a short idle gap
  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    check(exp_q.size(), 0);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic cmd(input logic [7:0] p[$], input logic [7:0] ans);
    exp_q.push_back(ans);
    i_sbl_host_model.send_pkt(p);
    drain();
  endtask

  task automatic query(input logic [7:0] st);
    check(last_status, st);
    exp_q.push_back(ACK_BYTE);
    exp_q.push_back(LEN_REPLY);
    exp_q.push_back(st);
    exp_q.push_back(st);
    i_sbl_host_model.send_pkt('{CMD_QUERY});
    drain();
    i_sbl_host_model.reply(ACK_BYTE);
    repeat (2) @(negedge sys_clk);
  endtask

  // bytes sent exactly as given, for packets that must be refused
  task automatic raw(input logic [7:0] p[$], input logic [7:0] ans);
    exp_q.push_back(ans);
    foreach (p[i]) i_sbl_host_model.send_byte(p[i]);
    drain();
  endtask

  // pulse must follow the taken acknowledge, never precede it
  task automatic wait_req(input bit rst_cmd);
    repeat (200) begin
      @(posedge sys_clk);
      if (rst_cmd ? sys_reset_req : run_req) begin
        check(exp_q.size(), 0);
        return;
      end
    end
    check(1'b0, 1'b1);
  endtask

  initial begin
    logic [31:0] a;
    logic [7:0]  d[$];
    logic [7:0]  b;
    void'($urandom(32'he5d1));
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    check(last_status, ST_RESET);
    exp_q.push_back(ACK_BYTE);
    i_sbl_host_model.sync_pair();
    drain();
    // a ping on the other port must be ignored once uart is locked
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      sp_rx_valid = 1'b1;
      sp_rx_data  = (i == 0) ? LEN_SHORT : CMD_PING;
      @(negedge sys_clk);
      sp_rx_valid = 1'b0;
    end
    cmd('{CMD_PING}, ACK_BYTE);
    query(ST_SUCCESS);
    raw('{8'h03, 8'h21, 8'h20}, NAK_BYTE);
    raw('{8'h02}, NAK_BYTE);
    cmd('{8'h2f}, ACK_BYTE);
    query(ST_UNKNOWN);
    cmd('{CMD_PING, 8'h00}, ACK_BYTE);
    query(ST_INVALID);
    cmd('{CMD_DATA, 8'h11}, ACK_BYTE);
    query(ST_FAIL);
    a = $urandom;
    exp_addr = a;
    exp_size = 32'h0000_000a;
    cmd('{CMD_DOWNLOAD, a[31:24], a[23:16], a[15:8], a[7:0],
          8'h00, 8'h00, 8'h00, 8'h0a}, ACK_BYTE);
    query(ST_SUCCESS);
    // a data packet with a bad sum must leave the address where it was
    raw('{8'h04, 8'h00, CMD_DATA, 8'h01}, NAK_BYTE);
    check(erase_addr, exp_addr);
    for (int k = 0; k < 2; k++) begin
      d = '{CMD_DATA};
      for (int i = 0; i < (k == 0 ? 8 : 2); i++) begin
        b = 8'($urandom);
        d.push_back(b);
        prog_q.push_back({a, b});
        a = a + 32'h1;
      end
      cmd(d, ACK_BYTE);
      query(ST_SUCCESS);
    end
    check(erase_addr, exp_addr + 32'h0000_000a);
    check(erase_size, 32'h0000_0000);
    check(prog_q.size(), 0);
    cmd('{CMD_DATA, 8'h5a}, ACK_BYTE);
    query(ST_FAIL);
    a = $urandom;
    exp_q.push_back(ACK_BYTE);
    i_sbl_host_model.send_pkt('{CMD_RUN, a[31:24], a[23:16], a[15:8], a[7:0]});
    wait_req(1'b0);
    check(run_addr, a);
    // second reset clears the port lock, so sync again
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    check(uart_tx_valid, 1'b0);
    exp_q.push_back(ACK_BYTE);
    i_sbl_host_model.sync_pair();
    drain();
    exp_q.push_back(ACK_BYTE);
    i_sbl_host_model.send_pkt('{CMD_RESET});
    wait_req(1'b1);
    repeat (4) @(negedge sys_clk);
    stop_test();
  end
endmodule
